//--- src/tsr_defines.svh
`ifndef TSR_DEFINES_SVH
`define TSR_DEFINES_SVH
// instruction fields, little-endian bit numbering: bit 0 is the lsb of the word
`define TSR_PRIMARY_OP 6'h1f
`define TSR_XO_LOAD_DATA 10'h3d2
`define TSR_XO_LOAD_INSTR 10'h3f2
`define TSR_XO_SYNC 10'h236
`define TSR_POP_MSB 31
`define TSR_POP_LSB 26
`define TSR_SRC_MSB 15
`define TSR_SRC_LSB 11
`define TSR_XO_MSB 10
`define TSR_XO_LSB 1
`define TSR_RECORD_POS 0
`define TSR_ZERO_WORD 32'h00000000
// page offset kept from the miss address when merging the lower word
`define TSR_PAGE_OFS_BITS 12
`endif

//--- src/tsr_pkg.sv
package tsr_pkg;
  typedef enum logic [2:0]
  {
    TSR_IDLE = 3'b001,
    TSR_LOAD = 3'b010,
    TSR_WAIT = 3'b100
  } tsr_state_e;
  typedef enum logic [1:0]
  {
    TSR_OP_NONE = 2'h0,
    TSR_OP_LDD = 2'h1,
    TSR_OP_LDI = 2'h2,
    TSR_OP_SYNC = 2'h3
  } tsr_op_e;
endpackage

//--- src/tsr_tlb_array.sv
`timescale 1ns/1ps
`include "tsr_defines.svh"
// one side's translation buffer: lookup by virtual page, write by index
module tsr_tlb_array
  import tsr_pkg::*;
#(
  parameter int ENTRIES = 32,
  parameter int IDX_W = 5
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [31:0] wr_hi,
  input wire logic [31:0] wr_lo,
  input wire logic [31:0] lk_tag,
  output logic lk_hit,
  output logic [31:0] lk_lo
);
  logic [31:0] hi_ff [ENTRIES];
  logic [31:0] lo_ff [ENTRIES];
  logic [ENTRIES-1:0] vld_ff;

  // only the chosen entry changes; others keep contents
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      vld_ff <= '0;
      for (int i = 0; i < ENTRIES; i++)
      begin
        hi_ff[i] <= `TSR_ZERO_WORD;
        lo_ff[i] <= `TSR_ZERO_WORD;
      end
    end
    else if (wr_en)
    begin
      hi_ff[wr_idx] <= wr_hi;
      lo_ff[wr_idx] <= wr_lo;
      vld_ff[wr_idx] <= 1'b1;
    end
  end

  // fully associative compare of the upper word
  always_comb
  begin
    lk_hit = 1'b0;
    lk_lo = `TSR_ZERO_WORD;
    for (int i = 0; i < ENTRIES; i++)
    begin
      if (vld_ff[i] && hi_ff[i] == lk_tag && !lk_hit)
      begin
        lk_hit = 1'b1;
        lk_lo = lo_ff[i];
      end
    end
  end
endmodule // tsr_tlb_array

//--- src/tsr_tlb_reload.sv
`timescale 1ns/1ps
`include "tsr_defines.svh"
// Behaviour
// - flag a miss when a lookup finds no matching buffer entry.
// - data miss captures faulting effective address into data miss address register.
// - data miss loads first page entry word into data miss compare register.
// - instruction miss captures faulting effective address into instruction miss address.
// - instruction miss loads first page entry word into instruction compare register.
// - load-entry writes the entry indexed by the source register's value.
// - data load writes data compare register into entry upper word.
// - data load merges real page and data miss address into lower word.
// - instruction load writes instruction compare register into upper word.
// - instruction load merges real page and instruction miss address into lower.
// - record bit set makes any of the three invalid; exception register untouched.
// - instruction load-entry runs only in privileged state.
// - synchronise completes only after all others finish earlier invalidations.
module tsr_tlb_reload
  import tsr_pkg::*;
#(
  parameter int ENTRIES = 32,
  parameter int IDX_W = 5
)
(
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic INSN_VALID,
  input wire logic [31:0] INSN_WORD,
  input wire logic [31:0] SRC_REG_VALUE,
  input wire logic PRIV_STATE,
  output logic [4:0] SRC_REG_FIELD,
  output logic INSN_DONE,
  output logic INSN_INVALID,
  output logic INSN_PRIV_FAULT,
  output logic INSN_BUSY,
  input wire logic [31:0] REAL_PAGE_ADDR,
  input wire logic D_LOOKUP_VALID,
  input wire logic [31:0] D_LOOKUP_EA,
  input wire logic [31:0] D_LOOKUP_VPN,
  input wire logic [31:0] D_PTE_WORD0,
  output logic D_MISS,
  output logic D_HIT,
  output logic [31:0] D_HIT_LO,
  input wire logic I_LOOKUP_VALID,
  input wire logic [31:0] I_LOOKUP_EA,
  input wire logic [31:0] I_LOOKUP_VPN,
  input wire logic [31:0] I_PTE_WORD0,
  output logic I_MISS,
  output logic I_HIT,
  output logic [31:0] I_HIT_LO,
  output logic [31:0] DATA_MISS_ADDR,
  output logic [31:0] DATA_MISS_CMP,
  output logic [31:0] INSTR_MISS_ADDR,
  output logic [31:0] INSTR_MISS_CMP,
  input wire logic INVAL_PENDING,
  input wire logic REMOTE_ACKS_DONE
);
  localparam int OFS = `TSR_PAGE_OFS_BITS;

  // sequencer state
  tsr_state_e state_ff;
  tsr_state_e nxt_state;

  // what the taken instruction asked for
  tsr_op_e op_ff;
  logic [IDX_W-1:0] idx_ff;

  // miss registers and the page address taken with the instruction
  logic [31:0] data_miss_addr_reg_ff;
  logic [31:0] data_miss_compare_reg_ff;
  logic [31:0] instr_miss_addr_reg_ff;
  logic [31:0] instr_miss_compare_reg_ff;
  logic [31:0] real_page_addr_reg_ff;

  // one-cycle answers on the instruction port
  logic done_ff;
  logic invalid_ff;
  logic priv_fault_ff;

  // registered lookup answers
  logic d_miss_ff;
  logic i_miss_ff;
  logic d_hit_ff;
  logic i_hit_ff;
  logic [31:0] d_hit_lo_ff;
  logic [31:0] i_hit_lo_ff;

  // raw lookup results from the two buffers
  logic d_hit_c;
  logic i_hit_c;
  logic [31:0] d_lo_c;
  logic [31:0] i_lo_c;
  logic d_miss_c;
  logic i_miss_c;

  // decode results and buffer write strobes
  logic [9:0] dec_xo;
  tsr_op_e dec_op;
  logic dec_rec;
  logic dec_take;
  logic wr_d;
  logic wr_i;

  // merge: page frame from real page register, offset from miss address
  function automatic logic [31:0] merge_lo(input logic [31:0] real_page_addr_reg, input logic [31:0] ea);
    merge_lo = {real_page_addr_reg[31:OFS], ea[OFS-1:0]};
  endfunction

  // extended opcode, shared by the three compares below
  assign dec_xo = INSN_WORD[`TSR_XO_MSB:`TSR_XO_LSB];

  // field decode of the three handled instructions
  always_comb
  begin
    dec_op = TSR_OP_NONE;
    if (INSN_WORD[`TSR_POP_MSB:`TSR_POP_LSB] == `TSR_PRIMARY_OP)
    begin
      if (dec_xo == `TSR_XO_LOAD_DATA)
        dec_op = TSR_OP_LDD;
      else if (dec_xo == `TSR_XO_LOAD_INSTR)
        dec_op = TSR_OP_LDI;
      else if (dec_xo == `TSR_XO_SYNC)
        dec_op = TSR_OP_SYNC;
    end
  end

  assign dec_rec = INSN_WORD[`TSR_RECORD_POS];
  // instructions are only taken when idle; the core holds them while busy
  assign dec_take = INSN_VALID && (dec_op != TSR_OP_NONE) && (state_ff == TSR_IDLE);
  assign SRC_REG_FIELD = INSN_WORD[`TSR_SRC_MSB:`TSR_SRC_LSB];
  assign INSN_BUSY = (state_ff != TSR_IDLE);

  // sequencing: load takes one cycle, sync waits for remote completion
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      TSR_IDLE:
      begin
        if (dec_take && !dec_rec && PRIV_STATE)
        begin
          if (dec_op == TSR_OP_SYNC)
            nxt_state = TSR_WAIT;
          else
            nxt_state = TSR_LOAD;
        end
      end
      TSR_LOAD:
      begin
        // the write lands on this edge; nothing can stall it
        nxt_state = TSR_IDLE;
      end
      TSR_WAIT:
      begin
        if (!INVAL_PENDING && REMOTE_ACKS_DONE)
          nxt_state = TSR_IDLE;
      end
      default: nxt_state = TSR_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      state_ff <= TSR_IDLE;
    else
      state_ff <= nxt_state;
  end

  // latch operation and entry index from the source register value
  // refused ops latch too; harmless, the sequencer stays idle then
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      op_ff <= TSR_OP_NONE;
      idx_ff <= '0;
      real_page_addr_reg_ff <= `TSR_ZERO_WORD;
    end
    else if (dec_take)
    begin
      op_ff <= dec_op;
      idx_ff <= SRC_REG_VALUE[IDX_W-1:0];
      real_page_addr_reg_ff <= REAL_PAGE_ADDR;
    end
  end

  // completion and fault pulses; no exception register is touched here
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      done_ff <= 1'b0;
      invalid_ff <= 1'b0;
      priv_fault_ff <= 1'b0;
    end
    else
    begin
      invalid_ff <= dec_take && dec_rec;
      priv_fault_ff <= dec_take && !dec_rec && !PRIV_STATE;
      done_ff <= (state_ff == TSR_LOAD) ||
                 (state_ff == TSR_WAIT && nxt_state == TSR_IDLE);
    end
  end

  assign wr_d = (state_ff == TSR_LOAD) && (op_ff == TSR_OP_LDD);
  assign wr_i = (state_ff == TSR_LOAD) && (op_ff == TSR_OP_LDI);

  // data side buffer
  tsr_tlb_array #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) u_dtlb
  (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .wr_en(wr_d),
    .wr_idx(idx_ff),
    .wr_hi(data_miss_compare_reg_ff),
    .wr_lo(merge_lo(real_page_addr_reg_ff, data_miss_addr_reg_ff)),
    .lk_tag(D_LOOKUP_VPN),
    .lk_hit(d_hit_c),
    .lk_lo(d_lo_c)
  );

  // instruction side buffer
  tsr_tlb_array #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) u_itlb
  (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .wr_en(wr_i),
    .wr_idx(idx_ff),
    .wr_hi(instr_miss_compare_reg_ff),
    .wr_lo(merge_lo(real_page_addr_reg_ff, instr_miss_addr_reg_ff)),
    .lk_tag(I_LOOKUP_VPN),
    .lk_hit(i_hit_c),
    .lk_lo(i_lo_c)
  );

  // a lookup misses when it is requested and no valid entry matches
  assign d_miss_c = D_LOOKUP_VALID && !d_hit_c;
  assign i_miss_c = I_LOOKUP_VALID && !i_hit_c;

  // lookup results registered one cycle after the request
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      d_miss_ff <= 1'b0;
      i_miss_ff <= 1'b0;
      d_hit_ff <= 1'b0;
      i_hit_ff <= 1'b0;
      d_hit_lo_ff <= `TSR_ZERO_WORD;
      i_hit_lo_ff <= `TSR_ZERO_WORD;
    end
    else
    begin
      d_miss_ff <= d_miss_c;
      i_miss_ff <= i_miss_c;
      d_hit_ff <= D_LOOKUP_VALID && d_hit_c;
      i_hit_ff <= I_LOOKUP_VALID && i_hit_c;
      d_hit_lo_ff <= (D_LOOKUP_VALID && d_hit_c) ? d_lo_c : `TSR_ZERO_WORD;
      i_hit_lo_ff <= (I_LOOKUP_VALID && i_hit_c) ? i_lo_c : `TSR_ZERO_WORD;
    end
  end

  // data miss capture; holds until the next data miss
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      data_miss_addr_reg_ff <= `TSR_ZERO_WORD;
      data_miss_compare_reg_ff <= `TSR_ZERO_WORD;
    end
    else if (d_miss_c)
    begin
      data_miss_addr_reg_ff <= D_LOOKUP_EA;
      data_miss_compare_reg_ff <= D_PTE_WORD0;
    end
  end

  // instruction miss capture
  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      instr_miss_addr_reg_ff <= `TSR_ZERO_WORD;
      instr_miss_compare_reg_ff <= `TSR_ZERO_WORD;
    end
    else if (i_miss_c)
    begin
      instr_miss_addr_reg_ff <= I_LOOKUP_EA;
      instr_miss_compare_reg_ff <= I_PTE_WORD0;
    end
  end

  // instruction port answers
  assign INSN_DONE = done_ff;
  assign INSN_INVALID = invalid_ff;
  assign INSN_PRIV_FAULT = priv_fault_ff;

  // lookup answers
  assign D_MISS = d_miss_ff;
  assign I_MISS = i_miss_ff;
  assign D_HIT = d_hit_ff;
  assign I_HIT = i_hit_ff;
  assign D_HIT_LO = d_hit_lo_ff;
  assign I_HIT_LO = i_hit_lo_ff;

  // miss registers as read back by the reload software
  assign DATA_MISS_ADDR = data_miss_addr_reg_ff;
  assign DATA_MISS_CMP = data_miss_compare_reg_ff;
  assign INSTR_MISS_ADDR = instr_miss_addr_reg_ff;
  assign INSTR_MISS_CMP = instr_miss_compare_reg_ff;
endmodule // tsr_tlb_reload

//--- sim/tsr_tlb_reload_sva.sv
`timescale 1ns/1ps
`include "tsr_defines.svh"
module tsr_tlb_reload_sva
  import tsr_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic INSN_VALID,
  input wire logic [31:0] INSN_WORD,
  input wire logic PRIV_STATE,
  input wire logic INSN_BUSY,
  input wire logic INSN_DONE,
  input wire logic INSN_INVALID,
  input wire logic INSN_PRIV_FAULT,
  input wire logic D_LOOKUP_VALID,
  input wire logic [31:0] D_LOOKUP_EA,
  input wire logic [31:0] D_PTE_WORD0,
  input wire logic D_MISS,
  input wire logic D_HIT,
  input wire logic [31:0] DATA_MISS_ADDR,
  input wire logic [31:0] DATA_MISS_CMP,
  input wire logic I_LOOKUP_VALID,
  input wire logic [31:0] I_LOOKUP_EA,
  input wire logic [31:0] I_PTE_WORD0,
  input wire logic I_MISS,
  input wire logic I_HIT,
  input wire logic [31:0] INSTR_MISS_ADDR,
  input wire logic [31:0] INSTR_MISS_CMP,
  input wire logic INVAL_PENDING,
  input wire logic REMOTE_ACKS_DONE
);
  // decode of the three ops, independent of the design's decoder
  wire logic [9:0] xo = INSN_WORD[`TSR_XO_MSB:`TSR_XO_LSB];
  wire logic take = INSN_VALID && !INSN_BUSY && INSN_WORD[31:26] == `TSR_PRIMARY_OP &&
    (xo == `TSR_XO_LOAD_DATA || xo == `TSR_XO_LOAD_INSTR || xo == `TSR_XO_SYNC);
  wire logic ok = take && !INSN_WORD[0] && PRIV_STATE;
  logic sync_ff;
  // a privileged sync still waiting for the acknowledge condition
  always_ff @(posedge CORE_CLK or negedge ARST_N)
    if (!ARST_N)
      sync_ff <= 1'b0;
    else if (ok && xo == `TSR_XO_SYNC)
      sync_ff <= 1'b1;
    else if (!INVAL_PENDING && REMOTE_ACKS_DONE)
      sync_ff <= 1'b0;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);
  property p_data_miss_addr_reg; D_LOOKUP_VALID |=> (D_MISS ^ D_HIT) && (!D_MISS ||
    DATA_MISS_ADDR == $past(D_LOOKUP_EA) && DATA_MISS_CMP == $past(D_PTE_WORD0)); endproperty
  a_data_miss_addr_reg: assert property (p_data_miss_addr_reg) else $error("data miss capture wrong");
  property p_instr_miss_addr_reg; I_LOOKUP_VALID |=> (I_MISS ^ I_HIT) && (!I_MISS ||
    INSTR_MISS_ADDR == $past(I_LOOKUP_EA) && INSTR_MISS_CMP == $past(I_PTE_WORD0)); endproperty
  a_instr_miss_addr_reg: assert property (p_instr_miss_addr_reg) else $error("instr miss capture wrong");
  property p_inv; take && INSN_WORD[0] |=> INSN_INVALID && !INSN_PRIV_FAULT && !INSN_DONE;
  endproperty
  a_inv: assert property (p_inv) else $error("record form not refused");
  property p_priv; take && !INSN_WORD[0] && !PRIV_STATE |=> INSN_PRIV_FAULT && !INSN_DONE;
  endproperty
  a_priv: assert property (p_priv) else $error("problem state op not faulted");
  property p_load; ok && xo != `TSR_XO_SYNC |=> INSN_BUSY ##1 INSN_DONE && !INSN_BUSY;
  endproperty
  a_load: assert property (p_load) else $error("load timing wrong");
  property p_hold; sync_ff && (INVAL_PENDING || !REMOTE_ACKS_DONE) |=> INSN_BUSY && !INSN_DONE;
  endproperty
  a_hold: assert property (p_hold) else $error("sync done too early");
  property p_go; sync_ff && !INVAL_PENDING && REMOTE_ACKS_DONE |=> INSN_DONE ##1 !INSN_DONE;
  endproperty
  a_go: assert property (p_go) else $error("sync done missing");
  property p_junk; INSN_VALID && !INSN_BUSY && !take |=>
    !INSN_DONE && !INSN_INVALID && !INSN_PRIV_FAULT; endproperty
  a_junk: assert property (p_junk) else $error("foreign opcode answered");
endmodule // tsr_tlb_reload_sva

bind tsr_tlb_reload tsr_tlb_reload_sva u_sva
(
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .INSN_VALID(INSN_VALID), .INSN_WORD(INSN_WORD),
  .PRIV_STATE(PRIV_STATE), .INSN_BUSY(INSN_BUSY), .INSN_DONE(INSN_DONE),
  .INSN_INVALID(INSN_INVALID), .INSN_PRIV_FAULT(INSN_PRIV_FAULT),
  .D_LOOKUP_VALID(D_LOOKUP_VALID), .D_LOOKUP_EA(D_LOOKUP_EA), .D_PTE_WORD0(D_PTE_WORD0),
  .D_MISS(D_MISS), .D_HIT(D_HIT), .DATA_MISS_ADDR(DATA_MISS_ADDR),
  .DATA_MISS_CMP(DATA_MISS_CMP), .I_LOOKUP_VALID(I_LOOKUP_VALID),
  .I_LOOKUP_EA(I_LOOKUP_EA), .I_PTE_WORD0(I_PTE_WORD0), .I_MISS(I_MISS), .I_HIT(I_HIT),
  .INSTR_MISS_ADDR(INSTR_MISS_ADDR), .INSTR_MISS_CMP(INSTR_MISS_CMP),
  .INVAL_PENDING(INVAL_PENDING), .REMOTE_ACKS_DONE(REMOTE_ACKS_DONE)
);

//--- sim/tb_tsr_tlb_reload.sv
`timescale 1ns/1ps
`include "tsr_defines.svh"
module tb_tsr_tlb_reload;
  logic CORE_CLK = 0, ARST_N = 0, INSN_VALID = 0, PRIV_STATE = 1, D_LOOKUP_VALID = 0;
  logic INVAL_PENDING = 0, REMOTE_ACKS_DONE = 1, I_LOOKUP_VALID, INSN_DONE, INSN_INVALID;
  logic INSN_PRIV_FAULT, INSN_BUSY, D_MISS, D_HIT, I_MISS, I_HIT;
  logic [31:0] INSN_WORD = 0, SRC_REG_VALUE = 0, REAL_PAGE_ADDR = 32'h12345000;
  logic [31:0] D_LOOKUP_EA = 0, D_LOOKUP_VPN = 0, D_PTE_WORD0, I_LOOKUP_EA, I_LOOKUP_VPN;
  logic [31:0] I_PTE_WORD0, D_HIT_LO, I_HIT_LO, DATA_MISS_ADDR, DATA_MISS_CMP;
  logic [31:0] INSTR_MISS_ADDR, INSTR_MISS_CMP;
  logic [4:0] SRC_REG_FIELD;
  int bad_count = 0, samples_checked = 0;
  // instr side sees a skewed copy of the data lookup so both sides differ
  assign D_PTE_WORD0 = D_LOOKUP_VPN;
  assign I_LOOKUP_VALID = D_LOOKUP_VALID;
  assign I_LOOKUP_EA = D_LOOKUP_EA ^ 32'h00000111;
  assign I_LOOKUP_VPN = D_LOOKUP_VPN ^ 32'h00000001;
  assign I_PTE_WORD0 = I_LOOKUP_VPN;
  tsr_tlb_reload DUT
  (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .INSN_VALID(INSN_VALID), .INSN_WORD(INSN_WORD),
    .SRC_REG_VALUE(SRC_REG_VALUE), .PRIV_STATE(PRIV_STATE), .SRC_REG_FIELD(SRC_REG_FIELD),
    .INSN_DONE(INSN_DONE), .INSN_INVALID(INSN_INVALID), .INSN_PRIV_FAULT(INSN_PRIV_FAULT),
    .INSN_BUSY(INSN_BUSY), .REAL_PAGE_ADDR(REAL_PAGE_ADDR),
    .D_LOOKUP_VALID(D_LOOKUP_VALID), .D_LOOKUP_EA(D_LOOKUP_EA),
    .D_LOOKUP_VPN(D_LOOKUP_VPN), .D_PTE_WORD0(D_PTE_WORD0), .D_MISS(D_MISS), .D_HIT(D_HIT),
    .D_HIT_LO(D_HIT_LO), .I_LOOKUP_VALID(I_LOOKUP_VALID), .I_LOOKUP_EA(I_LOOKUP_EA),
    .I_LOOKUP_VPN(I_LOOKUP_VPN), .I_PTE_WORD0(I_PTE_WORD0), .I_MISS(I_MISS), .I_HIT(I_HIT),
    .I_HIT_LO(I_HIT_LO), .DATA_MISS_ADDR(DATA_MISS_ADDR), .DATA_MISS_CMP(DATA_MISS_CMP),
    .INSTR_MISS_ADDR(INSTR_MISS_ADDR), .INSTR_MISS_CMP(INSTR_MISS_CMP),
    .INVAL_PENDING(INVAL_PENDING), .REMOTE_ACKS_DONE(REMOTE_ACKS_DONE)
  );
  always #2 CORE_CLK = ~CORE_CLK;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one instruction, valid for a single edge
  task automatic issue(input logic [9:0] xo, input logic rec, input logic p, input logic [31:0] v);
    @(posedge CORE_CLK);
    INSN_VALID <= 1'b1;
    INSN_WORD <= {`TSR_PRIMARY_OP, 10'h000, 5'h03, xo, rec};
    SRC_REG_VALUE <= v;
    PRIV_STATE <= p;
    @(posedge CORE_CLK);
    INSN_VALID <= 1'b0;
    #1;
  endtask
  task automatic load(input logic [9:0] xo, input logic [31:0] v);
    issue(xo, 1'b0, 1'b1, v);
    chk({SRC_REG_FIELD, INSN_BUSY}, {5'h03, 1'b1});
    @(posedge CORE_CLK);
    #1;
    chk({INSN_DONE, INSN_BUSY}, 2'b10);
  endtask
  task automatic look(input logic [31:0] ea, input logic [31:0] vpn);
    @(posedge CORE_CLK);
    D_LOOKUP_VALID <= 1'b1;
    D_LOOKUP_EA <= ea;
    D_LOOKUP_VPN <= vpn;
    @(posedge CORE_CLK);
    D_LOOKUP_VALID <= 1'b0;
    #1;
  endtask
  // miss capture, both loads, then hits on the reloaded entries
  task automatic t_reload;
    look(32'h00005abc, 32'h80001234);
    chk({D_MISS, I_MISS, D_HIT, I_HIT}, 4'b1100);
    chk(DATA_MISS_ADDR, 32'h00005abc);
    chk(DATA_MISS_CMP, 32'h80001234);
    chk(INSTR_MISS_ADDR, 32'h00005bad);
    chk(INSTR_MISS_CMP, 32'h80001235);
    load(`TSR_XO_LOAD_DATA, 32'h00000025);
    look(32'h00007def, 32'h80001234);
    chk({D_HIT, I_MISS}, 2'b11);
    chk(D_HIT_LO, 32'h12345abc);
    load(`TSR_XO_LOAD_INSTR, 32'h00000009);
    look(32'h00000000, 32'h80001234);
    chk({D_HIT, I_HIT}, 2'b11);
    chk(I_HIT_LO, 32'h12345cfe);
    // reuse data index 5: old tag must go, instr side untouched
    look(32'h00001111, 32'h80009999);
    load(`TSR_XO_LOAD_DATA, 32'hffffffe5);
    look(32'h00000000, 32'h80001234);
    chk({D_MISS, I_HIT}, 2'b11);
    look(32'h00000000, 32'h80009999);
    chk({D_HIT, D_HIT_LO}, {1'b1, 32'h12345111});
    $display("reload test finished");
  endtask
  // record form and problem state on every op, then a foreign opcode
  task automatic t_refuse;
    logic [9:0] ops [3] = '{`TSR_XO_LOAD_DATA, `TSR_XO_LOAD_INSTR, `TSR_XO_SYNC};
    foreach (ops[i])
    begin
      issue(ops[i], 1'b1, 1'b1, 32'h0);
      chk({INSN_INVALID, INSN_PRIV_FAULT, INSN_DONE, INSN_BUSY}, 4'b1000);
      issue(ops[i], 1'b0, 1'b0, 32'h0);
      chk({INSN_INVALID, INSN_PRIV_FAULT, INSN_DONE, INSN_BUSY}, 4'b0100);
    end
    issue(10'h132, 1'b0, 1'b1, 32'h0);
    chk({INSN_INVALID, INSN_PRIV_FAULT, INSN_DONE, INSN_BUSY}, 4'b0000);
    $display("refuse test finished");
  endtask
  // both conditions needed: pending clears first, acks come later
  task automatic t_sync;
    @(posedge CORE_CLK);
    INVAL_PENDING <= 1'b1;
    REMOTE_ACKS_DONE <= 1'b0;
    issue(`TSR_XO_SYNC, 1'b0, 1'b1, 32'h0);
    repeat (4)
    begin
      chk({INSN_DONE, INSN_BUSY}, 2'b01);
      @(posedge CORE_CLK);
      #1;
    end
    @(posedge CORE_CLK);
    INVAL_PENDING <= 1'b0;
    #1;
    chk({INSN_DONE, INSN_BUSY}, 2'b01);
    @(posedge CORE_CLK);
    REMOTE_ACKS_DONE <= 1'b1;
    #1;
    chk({INSN_DONE, INSN_BUSY}, 2'b01);
    @(posedge CORE_CLK);
    #1;
    chk({INSN_DONE, INSN_BUSY}, 2'b10);
    $display("sync test finished");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    t_reload();
    t_refuse();
    t_sync();
    results();
  end
  // the tests need about 55 cycles; this is far beyond that
  initial
  begin
    #20000;
    bad_count++;
    results();
  end
endmodule // tb_tsr_tlb_reload
